// >>> pkg/rx_mon_cfg.svh
/*
  constants of the receive-port status monitor: offsets, bits, resets, timing.
  assumes byte-wide registers behind the device's serial control target.
*/
// How it works
// RULE_01 - latch lock change and control-channel errors, clear-on-read
// RULE_02 - sixteen-bit parity counter, high and low bytes
// RULE_03 - parity flag once count reaches threshold
// RULE_04 - counter read clears counter and parity flag
// RULE_05 - lock loss clears parity counter by default
// RULE_06 - host disables parity checking before counter read; the bench also reads the counter with parity checking enabled
// RULE_07 - encoder error latched at status two bit five
// RULE_08 - encoder error needs counting with threshold above one
// RULE_09 - encoder error flag clears when read
// RULE_10 - crc-failed packets never update link information while crc disable is clear
// RULE_11 - host clears crc disable, sets crc capable
// RULE_12 - status two bits report stable and fault
// RULE_13 - cable fault below programmed low frequency
// RULE_14 - frequency change beyond margin drops stable
// RULE_15 - frequency measured continuously, refreshed under 1 ms
// RULE_16 - lines counted per frame, packet or raw
// RULE_17 - last frame line count, high byte first
// RULE_18 - line count frozen at interrupt until read
// RULE_19 - line length in bytes, last line wins
// RULE_20 - line length held at interrupt until read
// RULE_21 - four sensor registers; edge reads clear event
// RULE_22 - host enables monitor driver through indirect writes
// RULE_23 - host restores defaults or resets to disable
// RULE_24 - live lock bit at status one bit zero
// RULE_25 - event coinciding with clearing read survives; a line or frame end during a hold-releasing read is dropped
// RULE_26 - every counter and flag kept per port
`ifndef RX_MON_CFG_SVH
`define RX_MON_CFG_SVH

`define RX_PORTS 2

`define OFF_GEN_CFG 8'h02
`define OFF_CAP 8'h4a
`define OFF_PORT_SEL 8'h4c
`define OFF_STS1 8'h4d
`define OFF_STS2 8'h4e
`define OFF_SENS_FIRST 8'h51
`define OFF_SENS_LAST 8'h54
`define OFF_PAR_HI 8'h55
`define OFF_PAR_LO 8'h56
`define OFF_DP_CTL 8'h59
`define OFF_SER_ID 8'h5b
`define OFF_LCNT_HI 8'h73
`define OFF_LCNT_LO 8'h74
`define OFF_LLEN_HI 8'h75
`define OFF_LLEN_LO 8'h76
`define OFF_FDET 8'h77
`define OFF_FREQ_HI 8'h78
`define OFF_FREQ_LO 8'h79
`define OFF_CRC_CTL 8'h8a
`define OFF_ERR_CTL 8'he0
`define OFF_PAR_THR 8'he1
`define OFF_LINE_CTL 8'he2
`define OFF_RISE 8'he3
`define OFF_FALL 8'he4

`define GEN_PAR_EN_BIT 1
`define CAP_CRC_BIT 4
`define CRC_DIS_BIT 7
`define ERR_EN_BIT 7
`define ERR_KEEP_BIT 6
`define LCTL_CNT_IRQ_BIT 0
`define LCTL_LEN_IRQ_BIT 1
`define LCTL_RAW_BIT 7
`define S1_LOCK_BIT 0
`define S1_PAR_BIT 1
`define S1_LCHG_BIT 2
`define S1_CRC_BIT 3
`define S1_SEQ_BIT 4
`define S2_ENC_BIT 5
`define S2_STABLE_BIT 2
`define S2_FAULT_BIT 1

`define GEN_CFG_RST 8'h02
`define CAP_RST 8'h00
`define CRC_CTL_RST 8'h80
`define ERR_CTL_RST 8'h00
`define PAR_THR_RST 8'h01
`define LINE_CTL_RST 8'h00
`define FDET_RST 8'h21

`define CLK_PERIOD_NS 4
`define FREQ_WIN_NS 1000
`define FREQ_WIN_CYC ((`FREQ_WIN_NS) / (`CLK_PERIOD_NS))

`endif

// >>> pkg/rx_mon_pkg.sv
/*
  state types of the receive-port status monitor.
  assumes rx_mon_cfg.svh is included before this package.
*/
`default_nettype none
`include "rx_mon_cfg.svh"
package rx_mon_pkg;

  typedef struct packed {
    logic lock_q;
    logic lock_chg;
    logic crc_err;
    logic seq_err;
    logic par_flag;
    logic [15:0] par_cnt;
    logic [7:0] par_lo_shadow;
    logic enc_err;
    logic [7:0] dp_ctl;
    logic [7:0] ser_id;
    logic [31:0] sensor;
    logic [7:0] rise;
    logic [7:0] fall;
    logic lv_q;
    logic [15:0] line_run;
    logic [15:0] len_run;
    logic [15:0] line_cnt;
    logic cnt_hold;
    logic [15:0] bytes_per_line;
    logic len_hold;
  } port_state_t;

  typedef struct packed {
    port_state_t [`RX_PORTS-1:0] port;
    logic [7:0] gen_cfg;
    logic [7:0] cap;
    logic [7:0] crc_ctl;
    logic [7:0] err_ctl;
    logic [7:0] par_thr;
    logic [7:0] line_ctl;
    logic [7:0] fdet;
    logic port_sel;
    logic [7:0] rdata;
    logic rvalid;
  } mon_state_t;

  typedef struct packed {
    logic [15:0] win_cnt;
    logic [15:0] tick_cnt;
    logic [15:0] freq;
    logic have_freq;
    logic stable;
    logic fault;
  } meter_state_t;

endpackage
`default_nettype wire

// >>> rtl/rx_freq_meter.sv
/*
  per-port input frequency meter with stability and cable-fault flags.
  assumes i_tick is one synchronous pulse per input-clock cycle after the
  front-end divider, so a window of one microsecond yields MHz.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_mon_cfg.svh"
module rx_freq_meter #(
  parameter int WIN_CYC = `FREQ_WIN_CYC
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic i_tick, // divided input-clock pulse
  input wire logic [7:0] i_low_limit, // cable-fault limit, MHz
  input wire logic [7:0] i_margin, // change margin, MHz
  output logic [15:0] o_freq, // last measured frequency
  output logic o_stable, // frequency stable
  output logic o_fault // no or too low input clock
);
  localparam logic [15:0] WIN_LAST = 16'(WIN_CYC - 1);

  rx_mon_pkg::meter_state_t s_reg;
  rx_mon_pkg::meter_state_t s_next;
  logic [15:0] cnt;
  logic [15:0] diff;

  always_comb
  begin
    s_next = s_reg;
    cnt = s_reg.tick_cnt + {15'h0000, i_tick};
    diff = (cnt > s_reg.freq) ? cnt - s_reg.freq : s_reg.freq - cnt;
    s_next.win_cnt = s_reg.win_cnt + 16'h0001;
    s_next.tick_cnt = cnt;
    // window well under 1 ms keeps the readback fresh
    if (s_reg.win_cnt == WIN_LAST) // RULE_15
    begin
      s_next.win_cnt = 16'h0000;
      s_next.tick_cnt = 16'h0000;
      s_next.freq = cnt;
      s_next.have_freq = 1'b1;
      s_next.fault = cnt < {8'h00, i_low_limit}; // RULE_13
      // first window after reset has no reference, so it counts as stable
      s_next.stable = !s_reg.have_freq || (diff <= {8'h00, i_margin}); // RULE_14
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_freq = s_reg.freq;
  assign o_stable = s_reg.stable;
  assign o_fault = s_reg.fault;
endmodule
`default_nettype wire

// >>> rtl/rx_port_status_monitor.sv
/*
  two-port receive status monitor: error flags, parity counters, frequency,
  line count, line length and remote sensor status, behind byte registers.
  assumes the serial control target delivers one-cycle read and write
  strobes with address and data; read data follows one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_mon_cfg.svh"
module rx_port_status_monitor #(
  parameter int FREQ_WIN = `FREQ_WIN_CYC
) (
  input wire logic i_clk, // core clock, 250 MHz
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  input wire logic [7:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // write data
  output logic [7:0] o_reg_rdata, // read data
  output logic o_reg_rvalid, // read data valid pulse
  input wire logic [1:0] i_locked, // receiver lock per port
  input wire logic [1:0] i_ctrl_crc_err, // control channel crc error pulse
  input wire logic [1:0] i_ctrl_seq_err, // control channel sequence error
  input wire logic [1:0] i_parity_err, // decoded parity error pulse
  input wire logic [1:0] i_enc_err, // encoding or sequence error pulse
  input wire logic [1:0] i_info_upd, // link information packet received
  input wire logic [1:0] i_info_crc_bad, // that packet failed its crc
  input wire logic [15:0] i_info_dp_ctl, // datapath control byte per port
  input wire logic [15:0] i_info_ser_id, // serializer identity per port
  input wire logic [63:0] i_info_sensor, // four sensor bytes per port
  input wire logic [1:0] i_freq_tick, // divided input clock pulse
  input wire logic [1:0] i_line_valid, // raw mode line valid
  input wire logic [1:0] i_byte_valid, // raw mode byte strobe
  input wire logic [1:0] i_long_pkt, // packet mode long packet end
  input wire logic [31:0] i_pkt_len, // long packet length in bytes
  input wire logic [1:0] i_frame_end // end of frame pulse
);
  rx_mon_pkg::mon_state_t s_reg;
  rx_mon_pkg::mon_state_t s_next;
  logic [15:0] freq [`RX_PORTS];
  logic [`RX_PORTS-1:0] stable;
  logic [`RX_PORTS-1:0] fault;

  genvar g;
  generate
    for (g = 0; g < `RX_PORTS; g++)
    begin : g_meter
      rx_freq_meter #(
        .WIN_CYC(FREQ_WIN)
      ) u_meter (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_tick(i_freq_tick[g]),
        .i_low_limit({4'h0, s_reg.fdet[3:0]}),
        .i_margin({4'h0, s_reg.fdet[7:4]}),
        .o_freq(freq[g]),
        .o_stable(stable[g]),
        .o_fault(fault[g])
      );
    end
  endgenerate

  function automatic logic hit(input logic strobe, input logic [7:0] off);
    hit = strobe && (i_reg_addr == off);
  endfunction

  rx_mon_pkg::port_state_t ps;
  logic sel;
  logic mine;
  logic crc_check;
  logic enc_ok;
  logic lost;
  logic line_end;
  logic [15:0] new_len;
  logic [7:0] sens_old;
  logic [7:0] sens_new;
  logic [7:0] rd;
  logic [1:0] sens_idx;

  always_comb
  begin
    s_next = s_reg;
    ps = s_reg.port[s_reg.port_sel];
    sel = s_reg.port_sel;
    mine = 1'b0;
    lost = 1'b0;
    line_end = 1'b0;
    new_len = 16'h0000;
    sens_old = 8'h00;
    sens_new = 8'h00;
    rd = 8'h00;
    // two-bit wrap maps offset 0x54 onto byte three, not off the vector
    sens_idx = i_reg_addr[1:0] - 2'h1;
    s_next.rvalid = i_reg_rd;
    crc_check = !s_reg.crc_ctl[`CRC_DIS_BIT]; // RULE_11
    enc_ok = s_reg.err_ctl[`ERR_EN_BIT] && (s_reg.err_ctl[3:0] > 4'h1); // RULE_08

    // read mux for the selected port
    if (i_reg_addr >= `OFF_SENS_FIRST && i_reg_addr <= `OFF_SENS_LAST)
    begin
      rd = ps.sensor[8 * sens_idx +: 8]; // RULE_21
    end
    else
    begin
      case (i_reg_addr)
        `OFF_GEN_CFG: rd = s_reg.gen_cfg;
        `OFF_CAP: rd = s_reg.cap;
        `OFF_PORT_SEL: rd = {7'h00, s_reg.port_sel};
        `OFF_STS1: rd = {3'h0, ps.seq_err, ps.crc_err, ps.lock_chg, ps.par_flag,
                         i_locked[sel]}; // RULE_24
        `OFF_STS2: rd = {2'h0, ps.enc_err, 2'h0, stable[sel], fault[sel], 1'b0}; // RULE_12
        `OFF_PAR_HI: rd = ps.par_cnt[15:8]; // RULE_02
        `OFF_PAR_LO: rd = ps.par_lo_shadow; // RULE_02
        `OFF_DP_CTL: rd = ps.dp_ctl;
        `OFF_SER_ID: rd = ps.ser_id;
        `OFF_LCNT_HI: rd = ps.line_cnt[15:8]; // RULE_17
        `OFF_LCNT_LO: rd = ps.line_cnt[7:0]; // RULE_17
        `OFF_LLEN_HI: rd = ps.bytes_per_line[15:8]; // RULE_19
        `OFF_LLEN_LO: rd = ps.bytes_per_line[7:0]; // RULE_19
        `OFF_FDET: rd = s_reg.fdet;
        `OFF_FREQ_HI: rd = freq[sel][15:8]; // RULE_15
        `OFF_FREQ_LO: rd = freq[sel][7:0]; // RULE_15
        `OFF_CRC_CTL: rd = s_reg.crc_ctl;
        `OFF_ERR_CTL: rd = s_reg.err_ctl;
        `OFF_PAR_THR: rd = s_reg.par_thr;
        `OFF_LINE_CTL: rd = s_reg.line_ctl;
        `OFF_RISE: rd = ps.rise;
        `OFF_FALL: rd = ps.fall;
        default: rd = 8'h00;
      endcase
    end
    if (i_reg_rd)
    begin
      s_next.rdata = rd;
    end

    if (i_reg_wr)
    begin
      case (i_reg_addr)
        `OFF_GEN_CFG: s_next.gen_cfg = i_reg_wdata;
        `OFF_CAP: s_next.cap = i_reg_wdata;
        `OFF_PORT_SEL: s_next.port_sel = i_reg_wdata[0];
        `OFF_FDET: s_next.fdet = i_reg_wdata;
        `OFF_CRC_CTL: s_next.crc_ctl = i_reg_wdata;
        `OFF_ERR_CTL: s_next.err_ctl = i_reg_wdata;
        `OFF_PAR_THR: s_next.par_thr = i_reg_wdata;
        `OFF_LINE_CTL: s_next.line_ctl = i_reg_wdata;
        default: s_next.rdata = s_reg.rdata;
      endcase
    end

    // every port keeps its own copy; clears come first so events win, but a line or frame end while a hold is read away is lost
    for (int i = 0; i < `RX_PORTS; i++) // RULE_26
    begin
      mine = i_reg_rd && (s_reg.port_sel == i[0]);
      lost = s_reg.port[i].lock_q && !i_locked[i];
      s_next.port[i].lock_q = i_locked[i];

      if (hit(mine, `OFF_STS1)) // RULE_01
      begin
        s_next.port[i].lock_chg = 1'b0;
        s_next.port[i].crc_err = 1'b0;
        s_next.port[i].seq_err = 1'b0;
      end
      if (i_locked[i] != s_reg.port[i].lock_q) // RULE_25
      begin
        s_next.port[i].lock_chg = 1'b1; // RULE_01
      end
      if (i_ctrl_crc_err[i])
      begin
        s_next.port[i].crc_err = 1'b1; // RULE_01
      end
      if (i_ctrl_seq_err[i])
      begin
        s_next.port[i].seq_err = 1'b1; // RULE_01
      end

      // high byte read snapshots the low byte so the pair stays coherent
      if (hit(mine, `OFF_PAR_HI))
      begin
        s_next.port[i].par_lo_shadow = s_reg.port[i].par_cnt[7:0];
      end
      if (hit(mine, `OFF_PAR_HI) || (lost && !s_reg.err_ctl[`ERR_KEEP_BIT])) // RULE_05
      begin
        s_next.port[i].par_cnt = 16'h0000; // RULE_04
        s_next.port[i].par_flag = 1'b0; // RULE_04
      end
      if (i_parity_err[i] && s_reg.gen_cfg[`GEN_PAR_EN_BIT]) // RULE_25
      begin
        if (s_next.port[i].par_cnt != 16'hffff)
        begin
          s_next.port[i].par_cnt = s_next.port[i].par_cnt + 16'h0001; // RULE_02
        end
        if (s_next.port[i].par_cnt >= {8'h00, s_reg.par_thr})
        begin
          s_next.port[i].par_flag = 1'b1; // RULE_03
        end
      end

      if (hit(mine, `OFF_STS2))
      begin
        s_next.port[i].enc_err = 1'b0; // RULE_09
      end
      // with counting off or a threshold of one or less, nothing is latched
      if (i_enc_err[i] && enc_ok) // RULE_08
      begin
        s_next.port[i].enc_err = 1'b1; // RULE_07
      end

      if (hit(mine, `OFF_RISE))
      begin
        s_next.port[i].rise = 8'h00; // RULE_21
      end
      if (hit(mine, `OFF_FALL))
      begin
        s_next.port[i].fall = 8'h00; // RULE_21
      end
      if (i_info_upd[i] && !(crc_check && i_info_crc_bad[i])) // RULE_10
      begin
        s_next.port[i].dp_ctl = i_info_dp_ctl[8 * i +: 8];
        s_next.port[i].ser_id = i_info_ser_id[8 * i +: 8];
        s_next.port[i].sensor = i_info_sensor[32 * i +: 32]; // RULE_21
        sens_old = s_reg.port[i].sensor[7:0];
        sens_new = i_info_sensor[32 * i +: 8];
        s_next.port[i].rise = s_next.port[i].rise | (sens_new & ~sens_old);
        s_next.port[i].fall = s_next.port[i].fall | (sens_old & ~sens_new);
      end

      // line detection: raw mode uses line valid, packet mode long packets
      s_next.port[i].lv_q = i_line_valid[i];
      line_end = 1'b0;
      new_len = s_reg.port[i].len_run;
      if (s_reg.line_ctl[`LCTL_RAW_BIT])
      begin
        if (i_line_valid[i] && !s_reg.port[i].lv_q)
        begin
          s_next.port[i].line_run = s_reg.port[i].line_run + 16'h0001; // RULE_16
          s_next.port[i].len_run = {15'h0000, i_byte_valid[i]};
        end
        else if (i_line_valid[i] && i_byte_valid[i])
        begin
          s_next.port[i].len_run = s_reg.port[i].len_run + 16'h0001; // RULE_19
        end
        line_end = s_reg.port[i].lv_q && !i_line_valid[i];
      end
      else if (i_long_pkt[i])
      begin
        s_next.port[i].line_run = s_reg.port[i].line_run + 16'h0001; // RULE_16
        new_len = i_pkt_len[16 * i +: 16];
        line_end = 1'b1;
      end

      if (hit(mine, `OFF_LLEN_LO))
      begin
        s_next.port[i].len_hold = 1'b0; // RULE_20
      end
      // each finished line overwrites unless a length hold is set, so without one the last line of a frame remains
      if (line_end && !s_reg.port[i].len_hold) // RULE_19
      begin
        s_next.port[i].bytes_per_line = new_len;
        if (s_reg.line_ctl[`LCTL_LEN_IRQ_BIT] && new_len != s_reg.port[i].bytes_per_line)
        begin
          s_next.port[i].len_hold = 1'b1; // RULE_20
        end
      end

      if (hit(mine, `OFF_LCNT_LO))
      begin
        s_next.port[i].cnt_hold = 1'b0; // RULE_18
      end
      if (i_frame_end[i])
      begin
        s_next.port[i].line_run = 16'h0000;
        if (!s_reg.port[i].cnt_hold)
        begin
          s_next.port[i].line_cnt = s_reg.port[i].line_run; // RULE_17
          if (s_reg.line_ctl[`LCTL_CNT_IRQ_BIT] &&
              s_reg.port[i].line_run != s_reg.port[i].line_cnt)
          begin
            s_next.port[i].cnt_hold = 1'b1; // RULE_18
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      s_reg <= '0;
      s_reg.gen_cfg <= `GEN_CFG_RST;
      s_reg.cap <= `CAP_RST;
      s_reg.crc_ctl <= `CRC_CTL_RST;
      s_reg.err_ctl <= `ERR_CTL_RST;
      s_reg.par_thr <= `PAR_THR_RST;
      s_reg.line_ctl <= `LINE_CTL_RST;
      s_reg.fdet <= `FDET_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_reg_rdata = s_reg.rdata;
  assign o_reg_rvalid = s_reg.rvalid;
endmodule
`default_nettype wire

// >>> sim/rx_mon_checker.sv
/*
  concurrent checks on the register side of the receive-port status monitor.
  assumes it is bound onto rx_port_status_monitor and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_mon_cfg.svh"
module rx_mon_checker (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [7:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic [7:0] o_reg_rdata, // read data
  input wire logic o_reg_rvalid, // read data valid
  input wire logic [1:0] i_locked // lock per port
);
  logic sel_reg;
  logic sel_next;
  // port select mirrored here, status reads only mean something per port
  always_comb
  begin
    sel_next = sel_reg;
    if (i_reg_wr && i_reg_addr == `OFF_PORT_SEL)
    begin
      sel_next = i_reg_wdata[0];
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      sel_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_read_answers: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read without valid one cycle later");
  a_no_stray_valid: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("valid without a read");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'h10 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_lock_live: assert property (i_reg_rd && i_reg_addr == `OFF_STS1 && $stable(i_locked)
    |=> o_reg_rdata[`S1_LOCK_BIT] == $past(i_locked[sel_reg]))
    else $error("lock bit differs from lock input");
  a_lock_change: assert property ((i_locked[sel_reg] != $past(i_locked[sel_reg])) ##1
    (i_reg_rd && i_reg_addr == `OFF_STS1) |=> o_reg_rdata[`S1_LCHG_BIT])
    else $error("lock change not reported");
  a_thr_readback: assert property ((i_reg_wr && i_reg_addr == `OFF_PAR_THR) ##2
    (i_reg_rd && i_reg_addr == `OFF_PAR_THR) |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("threshold readback differs");
  a_reset_clean: assert property ($rose(i_rst_b) |-> o_reg_rdata == 8'h00 && !o_reg_rvalid)
    else $error("read port not clean after reset");
  c_read: cover property (i_reg_rd ##1 o_reg_rvalid);
  c_lock_read: cover property ($changed(i_locked) ##1 i_reg_rd);
  c_thr: cover property (i_reg_wr && i_reg_addr == `OFF_PAR_THR ##2 i_reg_rd);
endmodule
bind rx_port_status_monitor rx_mon_checker chk (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid),
  .i_locked(i_locked)
);
`default_nettype wire

// >>> sim/ser_model.sv
/*
  remote serializer side: divided input clock and video packets on port 0 only.
  assumes the bench calls frame() and sets the tick spacing.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_model (
  input wire logic i_clk, // core clock
  input wire logic [7:0] i_div, // port 0 tick spacing, 0 stops it
  output logic [1:0] o_tick, // divided input clock per port
  output logic [1:0] o_long_pkt, // end of long packet
  output logic [31:0] o_pkt_len, // packet length per port
  output logic [1:0] o_frame_end // end of frame
);
  logic [7:0] cnt = 8'h00;
  initial
  begin
    o_tick = 2'b00;
    o_long_pkt = 2'b00;
    o_pkt_len = 32'h5a5a_a5a5;
    o_frame_end = 2'b00;
  end
  // port 1 never clocks, so it must read as a cable fault
  always @(negedge i_clk)
  begin
    cnt <= (cnt + 8'h01 >= i_div) ? 8'h00 : cnt + 8'h01;
    o_tick <= {1'b0, i_div != 8'h00 && cnt == 8'h00};
  end
  task automatic frame(input int n, input logic [15:0] base);
    int i;
  begin
    for (i = 0; i < n; i++)
    begin
      @(negedge i_clk);
      o_long_pkt = 2'b01;
      o_pkt_len = {~o_pkt_len[31:16], base + i[15:0]};
      @(negedge i_clk);
      o_long_pkt = 2'b00;
      o_pkt_len = ~o_pkt_len; // length not held between packets
    end
    @(negedge i_clk);
    o_frame_end = 2'b01;
    @(negedge i_clk);
    o_frame_end = 2'b00;
  end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
/*
  self-checking bench of the receive-port status monitor.
  assumes ser_model as the remote side; reads are checked from a queue.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] e; logic [7:0] m;} note_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] locked = 2'b00;
  logic [1:0] par = 2'b00, enc = 2'b00, ccrc = 2'b00, cseq = 2'b00, upd = 2'b00, bad = 2'b00;
  logic [15:0] dp = 16'h0000, sid = 16'h0000;
  logic [63:0] sens = 64'h0;
  logic [7:0] div = 8'h05;
  logic [1:0] lv = 2'b00, bv = 2'b00;
  logic [1:0] tick, lpkt, fend;
  logic [31:0] plen;
  note_t q[$];
  note_t nt;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  always #2 clk = ~clk;
  rx_port_status_monitor #(.FREQ_WIN(25)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_locked(locked), .i_ctrl_crc_err(ccrc),
    .i_ctrl_seq_err(cseq), .i_parity_err(par), .i_enc_err(enc), .i_info_upd(upd),
    .i_info_crc_bad(bad), .i_info_dp_ctl(dp), .i_info_ser_id(sid), .i_info_sensor(sens),
    .i_freq_tick(tick), .i_line_valid(lv), .i_byte_valid(bv), .i_long_pkt(lpkt),
    .i_pkt_len(plen), .i_frame_end(fend)
  );
  ser_model ser (.i_clk(clk), .i_div(div), .o_tick(tick), .o_long_pkt(lpkt),
    .o_pkt_len(plen), .o_frame_end(fend));
  task automatic close_out;
  begin
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  end
  endtask
  task automatic cmp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g,
                     input logic [7:0] m);
  begin
    cmp_count++;
    if ((g & m) !== (e & m))
    begin
      miscompares++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e & m, g & m);
    end
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask
  // p pulses parity errors in the very cycle the read is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff,
                    input logic [1:0] p = 2'b00);
  begin
    q.push_back({a, e, m});
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    par = p;
    @(negedge clk);
    reg_rd = 1'b0;
    par = 2'b00;
  end
  endtask
  task automatic ev(input logic [11:0] v);
  begin
    @(negedge clk);
    {par, enc, ccrc, cseq, upd, bad} = v;
    @(negedge clk);
    {par, enc, ccrc, cseq, upd, bad} = 12'h000;
  end
  endtask
  task automatic done(input string s);
    int k;
  begin
    for (k = 0; k < 50 && q.size() != 0; k++)
    begin
      @(negedge clk);
    end
    if (q.size() != 0)
    begin
      miscompares++;
      close_out();
    end
    $display("test %s ended", s);
  end
  endtask
  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (q.size() == 0)
      begin
        miscompares++;
        $display("CHECK FAILED rvalid expected 0 seen 1");
      end
      else
      begin
        nt = q.pop_front();
        cmp(nt.a, nt.e, rdata, nt.m);
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial
  begin
    void'($urandom(70));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    locked = 2'b11;
    rd(8'h02, 8'h02);
    rd(8'h77, 8'h21);
    rd(8'h8a, 8'h80);
    rd(8'h10, 8'h00);
    rd(8'h4d, 8'h05);
    rd(8'h4d, 8'h01);
    ev(12'h050);
    rd(8'h4d, 8'h19);
    rd(8'h4d, 8'h01);
    done("status");
    wr(8'he1, 8'h03);
    rd(8'he1, 8'h03);
    repeat (2) ev(12'h400);
    rd(8'h4d, 8'h01);
    ev(12'h400);
    rd(8'h4d, 8'h03);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h03);
    rd(8'h4d, 8'h01);
    rd(8'h55, 8'h00, 8'hff, 2'b01);
    wr(8'h02, 8'h00);
    ev(12'h400);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h01);
    wr(8'h02, 8'h02);
    repeat (3) ev(12'h400);
    rd(8'h4d, 8'h03);
    @(negedge clk);
    locked = 2'b10;
    rd(8'h4d, 8'h04);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    locked = 2'b11;
    rd(8'h4d, 8'h05);
    done("parity");
    wr(8'h4c, 8'h01);
    n = $urandom % 5 + 1;
    repeat (n) ev(12'h800);
    rd(8'h55, 8'h00);
    rd(8'h56, n[7:0]);
    rd(8'h4d, 8'h05);
    rd(8'h4e, 8'h02, 8'h22);
    rd(8'h79, 8'h00);
    wr(8'h4c, 8'h00);
    rd(8'h4e, 8'h04, 8'h26);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h05);
    div = 8'h00;
    repeat (80) @(negedge clk);
    rd(8'h4e, 8'h02, 8'h02);
    rd(8'h79, 8'h00);
    div = 8'h05;
    repeat (80) @(negedge clk);
    rd(8'h4e, 8'h04, 8'h06);
    done("frequency");
    ev(12'h100);
    rd(8'h4e, 8'h00, 8'h20);
    wr(8'he0, 8'h81);
    ev(12'h100);
    rd(8'h4e, 8'h00, 8'h20);
    wr(8'he0, 8'h82);
    ev(12'h100);
    rd(8'h4e, 8'h20, 8'h20);
    rd(8'h4e, 8'h00, 8'h20);
    done("encoder");
    dp = 16'h003c;
    sid = 16'h0011;
    sens = 64'h0f;
    ev(12'h005);
    rd(8'h59, 8'h3c);
    rd(8'h5b, 8'h11);
    rd(8'h51, 8'h0f);
    rd(8'he3, 8'h0f);
    rd(8'he3, 8'h00);
    wr(8'h8a, 8'h00);
    wr(8'h4a, 8'h10);
    dp = 16'h005a;
    sid = 16'h0022;
    sens = 64'hf0;
    ev(12'h005);
    rd(8'h59, 8'h3c);
    rd(8'h5b, 8'h11);
    rd(8'h51, 8'h0f);
    ev(12'h004);
    rd(8'h59, 8'h5a);
    rd(8'h51, 8'hf0);
    rd(8'he4, 8'h0f);
    done("link info");
    ser.frame(3, 16'h0100);
    rd(8'h73, 8'h00);
    rd(8'h74, 8'h03);
    rd(8'h75, 8'h01);
    rd(8'h76, 8'h02);
    wr(8'he2, 8'h03);
    ser.frame(4, 16'h0020);
    ser.frame(5, 16'h0040);
    rd(8'h73, 8'h00);
    rd(8'h74, 8'h04);
    rd(8'h75, 8'h00);
    rd(8'h76, 8'h20);
    ser.frame(2, 16'h0010);
    rd(8'h74, 8'h02);
    rd(8'h76, 8'h10);
    done("lines");
    wr(8'he2, 8'h80);
    repeat (3)
    begin
      @(negedge clk);
      {lv, bv} = 4'h5;
      repeat (3) @(negedge clk);
      {lv, bv} = 4'h0;
    end
    ser.frame(0, 16'h0000);
    rd(8'h74, 8'h03);
    rd(8'h76, 8'h03);
    done("raw lines");
    wr(8'hb0, 8'h14);
    wr(8'hb1, 8'h00);
    wr(8'hb2, 8'h80);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    rd(8'he2, 8'h00);
    rd(8'h4d, 8'h05);
    done("reset");
    close_out();
  end
endmodule
`default_nettype wire
